//--- rtl/ssmst_top.sv
// serial bus status and boot load error capture with apb registers
//
// Operation
// RULE1: slave bus address is read-only in bits 7:1, fixed at init.
// RULE2: master bus address is read-only in bits 15:9, fixed at init.
// RULE3: in load mode bit 24 sets when loading completes or errors; resets zero.
// RULE4: unexpected nack during master transaction sets sticky bit 25.
// RULE5: retry after lost arbitration; 16 consecutive losses abort and set bit 26.
// RULE6: misplaced start or stop during master transaction sets bit 27.
// RULE7: bad load checksum or missing config-done command sets bit 28.
// RULE8: load write to undefined register sets bit 29.
// RULE9: skip-checksum control bit 17 makes every checksum pass.
// RULE10: error flags hold until one written; zero write keeps; reserved read zero.
`timescale 1ns/1ps
`include "ssmst_map.svh"
module ssmst_top #(
  parameter int ARB_LIMIT = `SSMST_ARB_LIMIT
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire ssmst_pkg::ssmst_paddr_type i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_scl_pin,
  input wire logic i_sda_pin,
  input wire ssmst_pkg::ssmst_addr7_type i_slave_bus_addr,
  input wire ssmst_pkg::ssmst_addr7_type i_master_bus_addr,
  input wire logic i_boot_load_mode,
  input wire logic i_mst_busy,
  input wire logic i_mst_sda_out,
  input wire logic i_mst_ack_expected,
  input wire logic i_mst_done,
  input wire logic i_load_finished,
  input wire logic i_load_cksum_bad,
  input wire logic i_load_no_cfg_done,
  input wire logic i_load_unmapped,
  output logic o_mst_retry,
  output logic o_mst_abort,
  output logic o_irq
);
  import ssmst_pkg::*;

  // ----------------------------------------------------------------
  // link monitor
  // ----------------------------------------------------------------
  ssmst_mon_if u_mon_if ();
  assign u_mon_if.busy = i_mst_busy;
  assign u_mon_if.sda_out = i_mst_sda_out;
  assign u_mon_if.ack_expected = i_mst_ack_expected;

  ssmst_bus_mon u_bus_mon (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_scl_pin(i_scl_pin),
    .i_sda_pin(i_sda_pin),
    .mon(u_mon_if.monitor)
  );

  // ----------------------------------------------------------------
  // hardware-initialised straps
  // ----------------------------------------------------------------
  ssmst_addr7_type saddr_s1, saddr_s2, maddr_s1, maddr_s2;
  logic mode_s1, mode_s2;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      saddr_s1 <= 7'h00;
      saddr_s2 <= 7'h00;
      maddr_s1 <= 7'h00;
      maddr_s2 <= 7'h00;
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
    end else begin
      saddr_s1 <= i_slave_bus_addr;
      saddr_s2 <= saddr_s1;
      maddr_s1 <= i_master_bus_addr;
      maddr_s2 <= maddr_s1;
      mode_s1 <= i_boot_load_mode;
      mode_s2 <= mode_s1;
    end
  end

  ssmst_addr7_type slave_bus_address, next_slave_bus_address;
  ssmst_addr7_type master_bus_address, next_master_bus_address;
  logic load_mode, next_load_mode, strap_locked, next_strap_locked;
  logic [1:0] settle_cnt, next_settle_cnt;

  always_comb begin
    next_slave_bus_address = slave_bus_address;
    next_master_bus_address = master_bus_address;
    next_load_mode = load_mode;
    next_strap_locked = strap_locked;
    next_settle_cnt = settle_cnt;
    if (!strap_locked) begin
      if (settle_cnt == `SSMST_STRAP_SETTLE) begin
        // RULE1 capture slave address
        next_slave_bus_address = saddr_s2;
        // RULE2 capture master address
        next_master_bus_address = maddr_s2;
        next_load_mode = mode_s2;
        next_strap_locked = 1'b1;
      end else begin
        next_settle_cnt = settle_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      slave_bus_address <= 7'h00;
      master_bus_address <= 7'h00;
      load_mode <= 1'b0;
      strap_locked <= 1'b0;
      settle_cnt <= 2'h0;
    end else begin
      slave_bus_address <= next_slave_bus_address;
      master_bus_address <= next_master_bus_address;
      load_mode <= next_load_mode;
      strap_locked <= next_strap_locked;
      settle_cnt <= next_settle_cnt;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup_phase, wr_access, hit_status, hit_ctrl, hit_mask;
  assign setup_phase = i_psel & ~i_penable;
  assign wr_access = i_psel & i_penable & o_pready & i_pwrite;
  assign hit_status = (i_paddr == `SSMST_STATUS_OFS);
  assign hit_ctrl = (i_paddr == `SSMST_CTRL_OFS);
  assign hit_mask = (i_paddr == `SSMST_MASK_OFS);

  // ----------------------------------------------------------------
  // arbitration retry counter
  // ----------------------------------------------------------------
  logic [4:0] loss_cnt, next_loss_cnt;
  logic next_mst_retry, next_mst_abort, arb_limit_hit;
  assign arb_limit_hit = (loss_cnt == 5'(ARB_LIMIT - 1));

  always_comb begin
    next_loss_cnt = loss_cnt;
    next_mst_retry = 1'b0;
    next_mst_abort = 1'b0;
    if (u_mon_if.arb_evt) begin
      // RULE5 retry or abort
      if (arb_limit_hit) begin
        next_mst_abort = 1'b1;
        next_loss_cnt = 5'h00;
      end else begin
        next_mst_retry = 1'b1;
        next_loss_cnt = loss_cnt + 5'h01;
      end
    end else if (i_mst_done) begin
      next_loss_cnt = 5'h00;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      loss_cnt <= 5'h00;
      o_mst_retry <= 1'b0;
      o_mst_abort <= 1'b0;
    end else begin
      loss_cnt <= next_loss_cnt;
      o_mst_retry <= next_mst_retry;
      o_mst_abort <= next_mst_abort;
    end
  end

  // ----------------------------------------------------------------
  // status flags, control and mask
  // ----------------------------------------------------------------
  ssmst_err_type err, next_err, err_set, err_clr, err_keep, mask, next_mask;
  logic done, next_done, skip_cksum, next_skip_cksum;

  always_comb begin
    err_set = 5'h00;
    // RULE4 nack flag
    err_set[`SSMST_ERR_NACK] = u_mon_if.nack_evt;
    // RULE5 lost arbitration flag
    err_set[`SSMST_ERR_ARB] = u_mon_if.arb_evt & arb_limit_hit;
    // RULE6 framing flag
    err_set[`SSMST_ERR_FRAME] = u_mon_if.frame_evt;
    // RULE7 RULE9 checksum flag
    err_set[`SSMST_ERR_CKSUM] = (i_load_cksum_bad & ~skip_cksum) | i_load_no_cfg_done;
    // RULE8 unmapped target
    err_set[`SSMST_ERR_UNMAP] = i_load_unmapped;
    err_clr = (wr_access && hit_status) ? i_pwdata[`SSMST_ERR_MSB:`SSMST_ERR_LSB] : 5'h00;
    err_keep = err & ~err_clr;
    // RULE10 set wins over clear
    next_err = err_keep | err_set;
    // RULE3 load done
    next_done = done | (load_mode & (i_load_finished | err_set[`SSMST_ERR_CKSUM]
                | err_set[`SSMST_ERR_UNMAP]));
    next_skip_cksum = (wr_access && hit_ctrl) ? i_pwdata[`SSMST_SKIP_CKSUM_BIT] : skip_cksum;
    next_mask = (wr_access && hit_mask) ? i_pwdata[`SSMST_ERR_MSB:`SSMST_ERR_LSB] : mask;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      err <= `SSMST_ERR_RST;
      done <= 1'b0;
      skip_cksum <= 1'b0;
      mask <= `SSMST_MASK_RST;
      o_irq <= 1'b0;
    end else begin
      err <= next_err;
      done <= next_done;
      skip_cksum <= next_skip_cksum;
      mask <= next_mask;
      o_irq <= |(next_err & next_mask);
    end
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  logic [31:0] rd_mux, next_prdata;
  logic next_pready, next_pslverr;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_status) begin
      // RULE10 reserved bits zero
      rd_mux = {2'h0, err, done, 8'h00, master_bus_address, 1'b0, slave_bus_address, 1'b0};
    end else if (hit_ctrl) begin
      rd_mux[`SSMST_SKIP_CKSUM_BIT] = skip_cksum;
    end else if (hit_mask) begin
      rd_mux[`SSMST_ERR_MSB:`SSMST_ERR_LSB] = mask;
    end
    next_pready = setup_phase;
    next_pslverr = setup_phase & ~(hit_status | hit_ctrl | hit_mask);
    next_prdata = (setup_phase && !i_pwrite) ? rd_mux : 32'h0000_0000;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_prdata <= next_prdata;
      o_pready <= next_pready;
      o_pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking top_cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  AST_SLAVE_ADDR_FIXED: assert property (strap_locked |=> $stable(slave_bus_address)) // RULE1
    else $error("slave address changed after init");
  AST_MASTER_ADDR_FIXED: assert property ( // RULE2
    strap_locked |=> $stable(master_bus_address) && strap_locked)
    else $error("master address changed after init");
  AST_DONE_SET: assert property ( // RULE3
    (load_mode && i_load_finished) |=> done)
    else $error("load done not set");
  AST_DONE_GATED: assert property (!load_mode |-> !done) // RULE3
    else $error("load done set outside load mode");
  AST_NACK_FLAG: assert property ( // RULE4
    u_mon_if.nack_evt |=> err[`SSMST_ERR_NACK] && (o_irq || !mask[`SSMST_ERR_NACK]))
    else $error("nack flag not set");
  AST_ARB_ABORT: assert property ( // RULE5
    (u_mon_if.arb_evt && loss_cnt == 5'(ARB_LIMIT - 1))
      |=> o_mst_abort && !o_mst_retry && err[`SSMST_ERR_ARB] && loss_cnt == 5'h00)
    else $error("abort missing at loss limit");
  AST_ARB_RETRY: assert property ( // RULE5
    (u_mon_if.arb_evt && loss_cnt < 5'(ARB_LIMIT - 1))
      |=> o_mst_retry && !o_mst_abort && loss_cnt == $past(loss_cnt) + 5'h01)
    else $error("retry missing before loss limit");
  AST_FRAME_FLAG: assert property (u_mon_if.frame_evt |=> err[`SSMST_ERR_FRAME]) // RULE6
    else $error("framing flag not set");
  AST_CKSUM_FLAG: assert property ( // RULE7
    ((i_load_cksum_bad && !skip_cksum) || i_load_no_cfg_done) |=> err[`SSMST_ERR_CKSUM])
    else $error("checksum flag not set");
  AST_UNMAP_FLAG: assert property (i_load_unmapped |=> err[`SSMST_ERR_UNMAP]) // RULE8
    else $error("unmapped target flag not set");
  AST_SKIP_CKSUM: assert property ( // RULE9
    (skip_cksum && !i_load_no_cfg_done && !err[`SSMST_ERR_CKSUM]) |=> !err[`SSMST_ERR_CKSUM])
    else $error("checksum flag raised while skipped");
  AST_STICKY: assert property (1'b1 |=> ((err & $past(err_keep)) == $past(err_keep))) // RULE10
    else $error("error flag lost without clearing write");
  AST_IRQ_LEVEL: assert property (o_irq == |(err & mask))
    else $error("interrupt does not follow masked flags");

  COV_ABORT: cover property (o_mst_abort);
  COV_NACK_IRQ: cover property (err[`SSMST_ERR_NACK] && o_irq);
  COV_W1C: cover property (wr_access && hit_status && |err ##1 err == 5'h00);
endmodule : ssmst_top

//--- shared/ssmst_map.svh
// register map, field positions, reset values and counts of the serial bus status block
`ifndef SSMST_MAP_SVH
`define SSMST_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SSMST_ADDR_W 12
`define SSMST_STATUS_OFS 12'h424
`define SSMST_CTRL_OFS 12'h428
`define SSMST_MASK_OFS 12'h430

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SSMST_SADDR_LSB 1
`define SSMST_SADDR_MSB 7
`define SSMST_MADDR_LSB 9
`define SSMST_MADDR_MSB 15
`define SSMST_DONE_BIT 24
`define SSMST_ERR_LSB 25
`define SSMST_ERR_MSB 29
`define SSMST_SKIP_CKSUM_BIT 17
`define SSMST_ERR_NACK 0
`define SSMST_ERR_ARB 1
`define SSMST_ERR_FRAME 2
`define SSMST_ERR_CKSUM 3
`define SSMST_ERR_UNMAP 4

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define SSMST_ERR_RST 5'h00
`define SSMST_MASK_RST 5'h00
`define SSMST_ARB_LIMIT 16
`define SSMST_STRAP_SETTLE 2'h2
`define SSMST_ACK_SLOT 4'h8

`endif

//--- shared/ssmst_pkg.sv
// types shared by the serial bus status block
package ssmst_pkg;
  typedef logic [6:0] ssmst_addr7_type;
  typedef logic [4:0] ssmst_err_type;
  typedef logic [11:0] ssmst_paddr_type;
  typedef enum logic [0:0] {
    SSMST_MON_IDLE = 1'b0,
    SSMST_MON_FRAME = 1'b1
  } ssmst_mon_state_type;
endpackage : ssmst_pkg

//--- shared/ssmst_mon_if.sv
// link monitor events and master engine hints between core and monitor
`timescale 1ns/1ps
interface ssmst_mon_if;
  logic busy;
  logic sda_out;
  logic ack_expected;
  logic nack_evt;
  logic frame_evt;
  logic arb_evt;
  modport monitor (
    input busy,
    input sda_out,
    input ack_expected,
    output nack_evt,
    output frame_evt,
    output arb_evt
  );
  modport core (
    output busy,
    output sda_out,
    output ack_expected,
    input nack_evt,
    input frame_evt,
    input arb_evt
  );
endinterface : ssmst_mon_if

//--- rtl/ssmst_bus_mon.sv
// serial bus line monitor: start/stop, bit position, nack, misplaced conditions, lost arbitration
`timescale 1ns/1ps
`include "ssmst_map.svh"
module ssmst_bus_mon (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_scl_pin,
  input wire logic i_sda_pin,
  ssmst_mon_if.monitor mon
);
  import ssmst_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {i_scl_pin, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {i_sda_pin, sda_s1, sda_s2};
    end
  end

  logic start_cond, stop_cond, scl_rise, scl_fall;
  assign start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;

  // ----------------------------------------------------------------
  // frame tracker
  // ----------------------------------------------------------------
  ssmst_mon_state_type state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic nack_evt, next_nack_evt, frame_evt, next_frame_evt, arb_evt, next_arb_evt;
  // a clock rise becomes a bit only at the next fall; a start or stop in between drops it
  logic in_bit, next_in_bit, bit_val, next_bit_val;

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_in_bit = in_bit;
    next_bit_val = bit_val;
    next_nack_evt = 1'b0;
    next_frame_evt = 1'b0;
    next_arb_evt = 1'b0;
    case (state)
      SSMST_MON_IDLE: begin
        if (start_cond) begin
          next_state = SSMST_MON_FRAME;
          next_bit_cnt = 4'h0;
          next_in_bit = 1'b0;
        end
      end
      SSMST_MON_FRAME: begin
        if (start_cond || stop_cond) begin
          // RULE6 misplaced condition
          next_frame_evt = mon.busy && (bit_cnt != 4'h0);
          next_bit_cnt = 4'h0;
          next_in_bit = 1'b0;
          next_state = start_cond ? SSMST_MON_FRAME : SSMST_MON_IDLE;
        end else if (scl_rise) begin
          next_in_bit = 1'b1;
          next_bit_val = sda_s2;
        end else if (scl_fall && in_bit) begin
          next_in_bit = 1'b0;
          next_bit_cnt = (bit_cnt == `SSMST_ACK_SLOT) ? 4'h0 : bit_cnt + 4'h1;
          if (bit_cnt == `SSMST_ACK_SLOT) begin
            // RULE4 unexpected nack
            next_nack_evt = mon.busy & mon.ack_expected & bit_val;
          end else if (mon.busy & mon.sda_out & ~bit_val) begin
            // RULE5 arbitration lost
            next_arb_evt = 1'b1;
            next_state = SSMST_MON_IDLE;
          end
        end
      end
      default: next_state = SSMST_MON_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state <= SSMST_MON_IDLE;
      bit_cnt <= 4'h0;
      in_bit <= 1'b0;
      bit_val <= 1'b1;
      nack_evt <= 1'b0;
      frame_evt <= 1'b0;
      arb_evt <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      in_bit <= next_in_bit;
      bit_val <= next_bit_val;
      nack_evt <= next_nack_evt;
      frame_evt <= next_frame_evt;
      arb_evt <= next_arb_evt;
    end
  end

  assign mon.nack_evt = nack_evt;
  assign mon.frame_evt = frame_evt;
  assign mon.arb_evt = arb_evt;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking mon_cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  AST_MISPLACED_START: assert property ( // RULE6
    (state == SSMST_MON_FRAME && start_cond && mon.busy && bit_cnt != 4'h0) |=> frame_evt)
    else $error("misplaced start not flagged");
  AST_NACK_SLOT: assert property ( // RULE4
    nack_evt |-> $past(bit_cnt) == `SSMST_ACK_SLOT)
    else $error("nack reported outside ack slot");
endmodule : ssmst_bus_mon

//--- verification/ssmst_link_model.sv
// far-side model of the master link: other devices driving the clock and data lines
`timescale 1ns/1ps
module ssmst_link_model (
  output logic o_scl,
  output logic o_sda
);
  // ----------------------------------------------------------------
  // line driving; quarter of the 125 ns link clock period
  // ----------------------------------------------------------------
  localparam real QTR = 31.25;
  // both lines pulled up; the clock stands still high between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    o_sda = 1'b1;
    #(QTR) o_scl = 1'b1;
    #(QTR) o_sda = 1'b0;
    #(QTR) o_scl = 1'b0;
    #(QTR);
  endtask : start_cond
  // data changes only while the clock is low
  task automatic put_bit(input logic v);
    o_sda = v;
    #(QTR) o_scl = 1'b1;
    #(2.0 * QTR) o_scl = 1'b0;
    #(QTR);
  endtask : put_bit
  // eight bits msb first, then the ack slot of the addressed device
  task automatic send_byte(input logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    put_bit(ack);
  endtask : send_byte
  // stop: data rises while the clock is high, then both lines released
  task automatic stop_cond();
    o_sda = 1'b0;
    #(QTR) o_scl = 1'b1;
    #(QTR) o_sda = 1'b1;
    #(2.0 * QTR);
  endtask : stop_cond
endmodule : ssmst_link_model

//--- verification/test_smbus_master_status_errors.sv
// self-checking bench of the serial bus status block over apb and the link lines
`timescale 1ns/1ps
`include "ssmst_map.svh"
module test_smbus_master_status_errors;
  import ssmst_pkg::*;
  // ----------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------
  localparam int ARB_N = 3;
  localparam ssmst_addr7_type SA = 7'h2b;
  localparam ssmst_addr7_type MA = 7'h71;
  localparam ssmst_paddr_type ST = `SSMST_STATUS_OFS;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  ssmst_paddr_type paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd_data;
  logic rd_err;
  logic busy = 1'b0;
  logic sda_out = 1'b1;
  logic ack_exp = 1'b0;
  logic [4:0] evt = 5'h00;
  logic retry;
  logic abort;
  logic irq;
  logic link_scl;
  logic link_sda;
  logic sda_line;
  int fail_count = 0;
  int n_tests = 0;
  int n_retry = 0;
  int n_abort = 0;
  always #5 clk_sys = ~clk_sys;
  // wired-and of the far side and the master engine on the data line
  assign sda_line = link_sda & sda_out;
  ssmst_link_model i_link (
    .o_scl(link_scl),
    .o_sda(link_sda)
  );
  ssmst_top #(.ARB_LIMIT(ARB_N)) i_dut (
    .i_clk_sys(clk_sys),
    .i_rst(rst),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .i_scl_pin(link_scl),
    .i_sda_pin(sda_line),
    .i_slave_bus_addr(SA),
    .i_master_bus_addr(MA),
    .i_boot_load_mode(1'b1),
    .i_mst_busy(busy),
    .i_mst_sda_out(sda_out),
    .i_mst_ack_expected(ack_exp),
    .i_mst_done(evt[0]),
    .i_load_finished(evt[1]),
    .i_load_cksum_bad(evt[2]),
    .i_load_no_cfg_done(evt[3]),
    .i_load_unmapped(evt[4]),
    .o_mst_retry(retry),
    .o_mst_abort(abort),
    .o_irq(irq)
  );
  always @(posedge clk_sys) begin
    if (retry === 1'b1) n_retry++;
    if (abort === 1'b1) n_abort++;
  end
  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // setup cycle, then access held until pready is sampled high
  task automatic apb(input logic wr, input ssmst_paddr_type a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input ssmst_paddr_type a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input string name, input ssmst_paddr_type a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(name, e, rd_data);
  endtask : rd_chk
  task automatic pulse(input int idx);
    @(posedge clk_sys);
    evt[idx] <= 1'b1;
    @(posedge clk_sys);
    evt <= 5'h00;
  endtask : pulse
  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask : settle
  task automatic frame(input logic [7:0] d, input logic ack);
    i_link.start_cond();
    i_link.send_byte(d, ack);
    i_link.stop_cond();
    settle();
  endtask : frame
  function automatic logic [31:0] stat(input logic done, input ssmst_err_type fl);
    stat = {2'h0, fl, done, 8'h00, MA, 1'b0, SA, 1'b0};
  endfunction : stat
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    rd_chk("status", ST, stat(1'b0, 5'h00));
    wr(ST, 32'hffff_ffff);
    rd_chk("status ro", ST, stat(1'b0, 5'h00));
    wr(`SSMST_MASK_OFS, 32'hffff_ffff);
    rd_chk("mask", `SSMST_MASK_OFS, 32'h3e00_0000);
    wr(`SSMST_CTRL_OFS, 32'hffff_ffff);
    rd_chk("control", `SSMST_CTRL_OFS, 32'h0002_0000);
    wr(`SSMST_CTRL_OFS, 32'h0000_0000);
    rd_chk("unmapped", 12'h434, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, rd_err});
    ack_exp <= 1'b1;
    frame(8'hff, 1'b1);
    rd_chk("idle nack", ST, stat(1'b0, 5'h00));
    busy <= 1'b1;
    frame(8'hff, 1'b1);
    rd_chk("nack", ST, stat(1'b0, 5'h01));
    chk("irq on", 32'h1, {31'h0, irq});
    wr(`SSMST_MASK_OFS, 32'h0000_0000);
    settle();
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`SSMST_MASK_OFS, 32'hffff_ffff);
    wr(ST, 32'h0000_0000);
    rd_chk("nack kept", ST, stat(1'b0, 5'h01));
    wr(ST, 32'h0200_0000);
    rd_chk("nack clear", ST, stat(1'b0, 5'h00));
    chk("irq off", 32'h0, {31'h0, irq});
    // master drives low itself, then a restart at the byte boundary
    i_link.start_cond();
    @(posedge clk_sys);
    sda_out <= 1'b0;
    i_link.send_byte(8'h00, 1'b0);
    @(posedge clk_sys);
    sda_out <= 1'b1;
    i_link.start_cond();
    frame(8'hff, 1'b0);
    rd_chk("clean", ST, stat(1'b0, 5'h00));
    i_link.start_cond();
    repeat (3) i_link.put_bit(1'b1);
    frame(8'hff, 1'b0);
    rd_chk("framing", ST, stat(1'b0, 5'h04));
    wr(ST, 32'h0800_0000);
    repeat (2) frame(8'h7f, 1'b0);
    rd_chk("two losses", ST, stat(1'b0, 5'h00));
    chk("retries", 32'h2, n_retry);
    pulse(0);
    repeat (ARB_N - 1) frame(8'h7f, 1'b0);
    chk("no abort", 32'h0, n_abort);
    frame(8'h7f, 1'b0);
    chk("abort", 32'h1, n_abort);
    rd_chk("arb flag", ST, stat(1'b0, 5'h02));
    busy <= 1'b0;
    pulse(4);
    rd_chk("unmapped load", ST, stat(1'b1, 5'h12));
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    rd_chk("reset", ST, stat(1'b0, 5'h00));
    pulse(1);
    rd_chk("load done", ST, stat(1'b1, 5'h00));
    pulse(2);
    rd_chk("checksum", ST, stat(1'b1, 5'h08));
    wr(ST, 32'h1000_0000);
    wr(`SSMST_CTRL_OFS, 32'h0002_0000);
    pulse(2);
    rd_chk("skip checksum", ST, stat(1'b1, 5'h00));
    pulse(3);
    rd_chk("no cfg done", ST, stat(1'b1, 5'h08));
    stop_test();
  end
endmodule : test_smbus_master_status_errors
